// file: dtc_bus_model.sv
// Purpose: far-side transceivers on busy, select and reset
// Assumes: pins wired, any party asserting wins
// Notes: bits are busy, select, reset from high to low
`timescale 1ns/100ps
module dtc_bus_model (
    // chip enables, low drives
    input wire logic [2:0] oe_n_i,
    // far-side senders
    input wire logic [2:0] far_i,
    // resolved levels
    output logic [2:0] pin_o
);
    assign pin_o = ~oe_n_i | far_i;
endmodule : dtc_bus_model

// file: dtc_defines.svh
// Purpose: constants for the differential transceiver control block
// Assumes: one 32-bit word per register on classic Wishbone
// Notes: offsets are byte addresses
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define DTC_ICR_OFF 8'h04
`define DTC_MODE_OFF 8'h08
`define DTC_TCR_OFF 8'h0C
`define DTC_STAT_OFF 8'h10

// ****************************************
// field positions
// ****************************************
`define DTC_ICR_DATA_BIT 0
`define DTC_ICR_ATN_BIT 1
`define DTC_ICR_SEL_BIT 2
`define DTC_ICR_BSY_BIT 3
`define DTC_ICR_ACK_BIT 4
`define DTC_ICR_DIFF_BIT 5
`define DTC_ICR_RST_BIT 7
`define DTC_MODE_ARB_BIT 0
`define DTC_MODE_TARGET_BIT 6
`define DTC_TCR_IO_BIT 0

// ****************************************
// reset values
// ****************************************
`define DTC_ICR_RST_VAL 8'h00
`define DTC_MODE_RST_VAL 8'h00
`define DTC_TCR_RST_VAL 8'h00

`endif

// file: dtc_pkg.sv
// Purpose: types for the differential transceiver control block
// Assumes: nothing beyond the defines header
// Notes: the enable group travels as one struct
package dtc_pkg;

    typedef struct packed {
        logic data_xcvr_enable;
        logic target_group_enable;
        logic initiator_group_enable;
        logic arbitration_id_drive;
        logic busy_drive_out;
        logic select_drive_out;
        logic bus_reset_drive_out;
    } dtc_xcvr_t;

    typedef enum logic [1:0] {
        DTC_BUS_IDLE,
        DTC_BUS_ACK
    } dtc_bus_state_t;

endpackage : dtc_pkg

// file: dtc_sync_reg.sv
// Purpose: one byte-wide control register with reset value and write strobe
// Assumes: synchronous active-low reset
// Notes: instantiated once per software control register
`timescale 1ns/100ps
module dtc_sync_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // write port
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    // stored value
    output logic [7:0] q_o
);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            q_o <= RESET_VAL;
        end else if (we_i) begin
            q_o <= wdata_i;
        end
    end

endmodule : dtc_sync_reg

// file: dtc_xcvr_checker.sv
// Purpose: port checks for the transceiver control block
// Assumes: one clock, synchronous active-low reset
// Notes: outputs lag their cause by one clock
`timescale 1ns/100ps
module dtc_xcvr_checker (
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // bus state, pins and enables
    input wire logic single_ended_strap_i,
    input wire logic bus_free_i,
    input wire logic busy_pin_i,
    input wire logic busy_pin_oe_n_o,
    input wire logic select_pin_oe_n_o,
    input wire logic bus_reset_pin_oe_n_o,
    input wire logic busy_receive_in_o,
    input wire dtc_pkg::dtc_xcvr_t xcvr_o
);
    import dtc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    reset_clear_a: assert property (disable iff (1'b0) !rstn_i |=> xcvr_o == 7'h00 && busy_pin_oe_n_o)
        else $error("outputs not cleared");
    group_excl_a: assert property (!(xcvr_o.target_group_enable && xcvr_o.initiator_group_enable))
        else $error("both groups on");
    arb_free_a: assert property (xcvr_o.arbitration_id_drive |-> $past(bus_free_i))
        else $error("arbitration without bus free");
    strap_input_a: assert property (!single_ended_strap_i |=> busy_pin_oe_n_o && select_pin_oe_n_o
        && bus_reset_pin_oe_n_o) else $error("pin driven in input mode");
    busy_oe_a: assert property (!busy_pin_oe_n_o |-> xcvr_o.busy_drive_out && $past(single_ended_strap_i))
        else $error("busy pin driven wrongly");
    select_oe_a: assert property (!select_pin_oe_n_o |-> xcvr_o.select_drive_out)
        else $error("select pin driven wrongly");
    reset_oe_a: assert property (xcvr_o.bus_reset_drive_out && $past(single_ended_strap_i) |-> !bus_reset_pin_oe_n_o)
        else $error("reset pin not driven");
    receive_copy_a: assert property ($past(rstn_i) |-> busy_receive_in_o == $past(busy_pin_i))
        else $error("busy receive not copied");
    ack_latency_a: assert property (s_req |=> (wb_ack_o || wb_err_o) ##1 !wb_ack_o)
        else $error("bus answer late");
endmodule : dtc_xcvr_checker

// file: dtc_xcvr_ctrl.sv
// Purpose: transceiver enables and pin direction for the differential variant
// Assumes: wishbone classic slave, one wait state, all inputs synchronous to clk_i
// Notes: outputs are registered, so they lag their cause by one clock
`timescale 1ns/100ps
`include "dtc_defines.svh"
module dtc_xcvr_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // bus state
    input wire logic single_ended_strap_i,
    input wire logic phase_match_i,
    input wire logic bus_free_i,
    // pins shared between bidirectional and receive-only use
    input wire logic busy_pin_i,
    input wire logic select_pin_i,
    input wire logic bus_reset_pin_i,
    output logic busy_pin_oe_n_o,
    output logic select_pin_oe_n_o,
    output logic bus_reset_pin_oe_n_o,
    // receivers as seen by the core
    output logic busy_receive_in_o,
    output logic select_receive_in_o,
    output logic bus_reset_receive_in_o,
    // transceiver control
    output dtc_pkg::dtc_xcvr_t xcvr_o
);
    import dtc_pkg::*;

    // ****************************************
    // bus decode
    // ****************************************
    dtc_bus_state_t bus_q;
    logic req;
    logic hit_icr;
    logic hit_mode;
    logic hit_tcr;
    logic hit_stat;
    logic mapped;
    logic wr_lane0;
    logic we_icr;
    logic we_mode;
    logic we_tcr;
    logic [7:0] icr_q;
    logic [7:0] mode_q;
    logic [7:0] tcr_q;
    logic single_ended;
    dtc_xcvr_t xcvr_d;

    // a strobe held through the ack cycle is not taken a second time
    assign req = wb_cyc_i && wb_stb_i && (bus_q == DTC_BUS_IDLE);
    assign hit_icr = (wb_adr_i == `DTC_ICR_OFF);
    assign hit_mode = (wb_adr_i == `DTC_MODE_OFF);
    assign hit_tcr = (wb_adr_i == `DTC_TCR_OFF);
    assign hit_stat = (wb_adr_i == `DTC_STAT_OFF);
    assign mapped = hit_icr || hit_mode || hit_tcr || hit_stat;

    // ****************************************
    // register write strobes
    // ****************************************
    // stat is read-only: a write there is acked and dropped
    // writes land at the edge where the master samples ack, never before it
    assign wr_lane0 = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign we_icr = wr_lane0 && hit_icr;
    assign we_mode = wr_lane0 && hit_mode;
    assign we_tcr = wr_lane0 && hit_tcr;

    // one answer per request; ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            bus_q <= DTC_BUS_IDLE;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            case (bus_q)
                DTC_BUS_IDLE: begin
                    wb_ack_o <= req && mapped;
                    wb_err_o <= req && !mapped;
                    if (req) begin
                        bus_q <= DTC_BUS_ACK;
                    end
                end
                DTC_BUS_ACK: begin
                    wb_ack_o <= 1'b0;
                    wb_err_o <= 1'b0;
                    bus_q <= DTC_BUS_IDLE;
                end
                default: begin
                    wb_ack_o <= 1'b0;
                    wb_err_o <= 1'b0;
                    bus_q <= DTC_BUS_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    dtc_sync_reg #(.RESET_VAL(`DTC_ICR_RST_VAL)) u_icr (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .we_i(we_icr),
        .wdata_i(wb_dat_i[7:0]),
        .q_o(icr_q)
    );

    dtc_sync_reg #(.RESET_VAL(`DTC_MODE_RST_VAL)) u_mode (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .we_i(we_mode),
        .wdata_i(wb_dat_i[7:0]),
        .q_o(mode_q)
    );

    dtc_sync_reg #(.RESET_VAL(`DTC_TCR_RST_VAL)) u_tcr (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .we_i(we_tcr),
        .wdata_i(wb_dat_i[7:0]),
        .q_o(tcr_q)
    );

    // read data registered with the ack; stat shows live outputs and strap
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req) begin
            if (hit_icr) begin
                wb_dat_o <= {24'h00_0000, icr_q};
            end else if (hit_mode) begin
                wb_dat_o <= {24'h00_0000, mode_q};
            end else if (hit_tcr) begin
                wb_dat_o <= {24'h00_0000, tcr_q};
            end else if (hit_stat) begin
                wb_dat_o <= {24'h00_0000, single_ended, xcvr_o};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // transceiver enables
    // ****************************************
    assign single_ended = single_ended_strap_i;

    // phase match only opens the data path for an initiator that is sending
    always_comb begin
        xcvr_d.data_xcvr_enable = icr_q[`DTC_ICR_DATA_BIT] &&
            (mode_q[`DTC_MODE_TARGET_BIT] ||
             (phase_match_i && !tcr_q[`DTC_TCR_IO_BIT]));
        xcvr_d.target_group_enable = mode_q[`DTC_MODE_TARGET_BIT] && icr_q[`DTC_ICR_DIFF_BIT];
        xcvr_d.initiator_group_enable = !mode_q[`DTC_MODE_TARGET_BIT] && icr_q[`DTC_ICR_DIFF_BIT];
        xcvr_d.arbitration_id_drive = mode_q[`DTC_MODE_ARB_BIT] && bus_free_i;
        xcvr_d.busy_drive_out = icr_q[`DTC_ICR_BSY_BIT];
        xcvr_d.select_drive_out = icr_q[`DTC_ICR_SEL_BIT];
        xcvr_d.bus_reset_drive_out = icr_q[`DTC_ICR_RST_BIT];
    end

    // registered so every pin comes from a flop; reset clears all enables
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            xcvr_o <= '0;
        end else begin
            xcvr_o <= xcvr_d;
        end
    end

    // ****************************************
    // shared pin direction
    // ****************************************
    // differential mode never drives these pins: external parts own the bus
    // the drive bits still reach xcvr_o so the external drivers can follow them
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            busy_pin_oe_n_o <= 1'b1;
            select_pin_oe_n_o <= 1'b1;
            bus_reset_pin_oe_n_o <= 1'b1;
        end else begin
            busy_pin_oe_n_o <= !(single_ended && xcvr_d.busy_drive_out);
            select_pin_oe_n_o <= !(single_ended && xcvr_d.select_drive_out);
            bus_reset_pin_oe_n_o <= !(single_ended && xcvr_d.bus_reset_drive_out);
        end
    end

    // receivers pass the pin in both strap modes; single-ended sees its own drive
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            busy_receive_in_o <= 1'b0;
            select_receive_in_o <= 1'b0;
            bus_reset_receive_in_o <= 1'b0;
        end else begin
            busy_receive_in_o <= busy_pin_i;
            select_receive_in_o <= select_pin_i;
            bus_reset_receive_in_o <= bus_reset_pin_i;
        end
    end

endmodule : dtc_xcvr_ctrl

// file: tb.sv
// Purpose: register-driven test of the transceiver control block
// Assumes: one wait state bus, one clock output lag
// Notes: far side modelled as wired pins
`timescale 1ns/100ps
`include "dtc_defines.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
    import dtc_pkg::*;
    logic clk_i = 0, rstn_i = 0, cyc = 0, stb = 0, we = 0, strap = 1, pm = 0, bf = 0, ack, err, ef;
    logic [7:0] adr = 8'h00, rd;
    logic [31:0] dat = 32'h0, rdo;
    logic [2:0] far = 3'h0, oen, pins, rcv;
    dtc_xcvr_t x;
    int bad_count = 0, comparisons = 0;
    always #12.5 clk_i = ~clk_i;
    dtc_xcvr_ctrl u_dtc_xcvr_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .wb_err_o(err),
        .single_ended_strap_i(strap), .phase_match_i(pm), .bus_free_i(bf), .busy_pin_i(pins[2]),
        .select_pin_i(pins[1]), .bus_reset_pin_i(pins[0]), .busy_pin_oe_n_o(oen[2]), .select_pin_oe_n_o(oen[1]),
        .bus_reset_pin_oe_n_o(oen[0]), .busy_receive_in_o(rcv[2]), .select_receive_in_o(rcv[1]),
        .bus_reset_receive_in_o(rcv[0]), .xcvr_o(x));
    dtc_bus_model u_dtc_bus_model (.oe_n_i(oen), .far_i(far), .pin_o(pins));
    task automatic finish_test();
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (ack !== 1'b1 && err !== 1'b1) begin
            bad_count++;
            finish_test();
        end
        ef = err;
        rd = rdo[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // two edges: output registered, then sampled by the check
    task automatic xchk(input dtc_xcvr_t e);
        repeat (2) @(posedge clk_i);
        `CHK(x, e)
    endtask : xchk
    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        wb(`DTC_ICR_OFF, 1'b0, 8'h00);
        `CHK(rd, `DTC_ICR_RST_VAL)
        wb(`DTC_MODE_OFF, 1'b0, 8'h00);
        `CHK(rd, `DTC_MODE_RST_VAL)
        wb(8'h00, 1'b1, 8'hFF);
        `CHK(ef, 1'b1)
        wb(`DTC_MODE_OFF, 1'b1, 8'h40);
        wb(`DTC_ICR_OFF, 1'b1, 8'h21);
        xchk(7'h60);
        wb(`DTC_MODE_OFF, 1'b1, 8'h00);
        pm <= 1'b1;
        xchk(7'h50);
        wb(`DTC_TCR_OFF, 1'b1, 8'h01);
        xchk(7'h10);
        wb(`DTC_MODE_OFF, 1'b1, 8'h01);
        xchk(7'h10);
        bf <= 1'b1;
        xchk(7'h18);
        wb(`DTC_ICR_OFF, 1'b1, 8'h8C);
        xchk(7'h0F);
        `CHK(oen, 3'b000)
        wb(`DTC_STAT_OFF, 1'b0, 8'h00);
        `CHK(rd, 8'h8F)
        strap <= 1'b0;
        xchk(7'h0F);
        `CHK(oen, 3'b111)
        // receivers trail the pin release by one more edge
        @(posedge clk_i);
        `CHK(rcv, 3'b000)
        far <= 3'b101;
        xchk(7'h0F);
        `CHK(rcv, 3'b101)
        rstn_i <= 1'b0;
        xchk(7'h00);
        `CHK(oen, 3'b111)
        finish_test();
    end
endmodule : tb
bind dtc_xcvr_ctrl dtc_xcvr_checker u_dtc_xcvr_checker (.*);
